// file: core/fspc_top.sv
// Flash status poll controller: register port, poll sequencer, link engine
//
// Function
// - Busy select 1 takes status bit 7 as busy, 0 takes bit 0.
// - Lane code 00 one lane, 01 two lanes, 10 four lanes; 11 reserved.
// - Length code 01 one status byte, 10 two bytes; 00 and 11 reserved.
// - Status byte read from the flash lands in config bits 15 to 8.
// - Software writes opcode into bits 7 to 0; controller sends it to flash.
// - Busy select bit 20, lanes 19:18, length 17:16; bits 31:21 read zero.
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module fspc_top
  import fspc_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_ce,
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic [31:0]      o_rd_data,
  input  wire logic        i_lnk_clk,
  input  wire logic [3:0]  i_io_in,
  output logic             o_cs_b,
  output logic             o_sck_en,
  output logic [3:0]       o_io_out,
  output logic [3:0]       o_io_oe,
  output logic             o_poll_active,
  output logic             o_flash_ready
);

  logic        busy_pos;
  logic [1:0]  lanes;
  logic [1:0]  len_sel;
  logic [7:0]  returned;
  logic [7:0]  opcode;
  logic [7:0]  second;
  logic [7:0]  poll_cnt;
  logic        done;
  fspc_core_e  st;
  fspc_xfer_s  xfer;
  logic        req_tgl;
  logic        ack_tgl;
  logic        ack_s1;
  logic        ack_s2;
  logic        ack_seen;
  logic        ack_new;
  logic [15:0] lnk_stat;
  fspc_pin_s   pin;
  logic        cfg_wr;
  logic        ctl_wr;
  logic        start;
  logic        clear;
  logic        flash_busy;
  logic [31:0] cfg_word;
  logic [31:0] ctl_word;

  // Decode of the register port
  assign cfg_wr = i_wr_en && (i_addr == FSPC_OFF_CFG);
  assign ctl_wr = i_wr_en && (i_addr == FSPC_OFF_CTL);
  assign start  = ctl_wr && i_wr_data[FSPC_CTL_START] && (st == C_IDLE);
  assign clear  = ctl_wr && i_wr_data[FSPC_CTL_CLR];

  // Busy flag picked from the status byte
  assign flash_busy = busy_pos ? returned[FSPC_BUSY_HI] : returned[FSPC_BUSY_LO];

  assign ack_new = ack_s2 ^ ack_seen;

  // Read views of the two words
  assign cfg_word = {11'h000, busy_pos, lanes, len_sel, returned, opcode};
  assign ctl_word = {poll_cnt, 8'h00, second, 6'h00, done, (st != C_IDLE)};

  // Configuration fields written by software
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      busy_pos <= 1'b0;
      lanes    <= FSPC_LANE_1;
      len_sel  <= 2'h0;
      opcode   <= 8'h00;
    end else if (i_ce && cfg_wr) begin
      busy_pos <= i_wr_data[FSPC_POS_BUSY];
      lanes    <= i_wr_data[FSPC_LANE_LSB +: 2];
      len_sel  <= i_wr_data[FSPC_LEN_LSB +: 2];
      opcode   <= i_wr_data[FSPC_OPC_LSB +: 8];
    end
  end

  // Returned status: the flash answer wins over a software write
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      returned <= 8'h00;
      second   <= 8'h00;
    end else if (i_ce) begin
      if (st == C_WAIT && ack_new) begin
        returned <= lnk_stat[15:8];
        second   <= lnk_stat[7:0];
      end else if (cfg_wr) begin
        returned <= i_wr_data[FSPC_RET_LSB +: 8];
      end
    end
  end

  // Acknowledge toggle from the link domain
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else if (i_ce) begin
      ack_s1 <= ack_tgl;
      ack_s2 <= ack_s1;
    end
  end

  // Poll sequencer
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st        <= C_IDLE;
      xfer      <= '0;
      req_tgl   <= 1'b0;
      ack_seen  <= 1'b0;
    end else if (i_ce) begin
      case (st)
        C_IDLE: begin
          if (start) begin
            xfer.opcode    <= opcode;
            xfer.lanes     <= lanes;
            xfer.two_bytes <= (len_sel == FSPC_LEN_2);
            st             <= C_REQ;
          end
        end
        C_REQ: begin
          req_tgl <= ~req_tgl;
          st      <= C_WAIT;
        end
        C_WAIT: begin
          if (ack_new) begin
            ack_seen <= ack_s2;
            st       <= C_CHECK;
          end
        end
        C_CHECK: begin
          st <= flash_busy ? C_REQ : C_IDLE;
        end
        default: st <= C_IDLE;
      endcase
    end
  end

  // Done flag: setting wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      done <= 1'b0;
    end else if (i_ce) begin
      if (st == C_CHECK && !flash_busy) begin
        done <= 1'b1;
      end else if (start || clear) begin
        done <= 1'b0;
      end
    end
  end

  // Number of status reads in the current poll, saturating
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      poll_cnt <= 8'h00;
    end else if (i_ce) begin
      if (start) begin
        poll_cnt <= 8'h00;
      end else if (st == C_REQ && poll_cnt != FSPC_CNT_MAX) begin
        poll_cnt <= poll_cnt + 8'h01;
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rd_data <= FSPC_RD_IDLE;
    end else if (i_ce) begin
      if (i_rd_en) begin
        case (i_addr)
          FSPC_OFF_CFG: o_rd_data <= cfg_word;
          FSPC_OFF_CTL: o_rd_data <= ctl_word;
          default:      o_rd_data <= FSPC_RD_IDLE;
        endcase
      end else begin
        o_rd_data <= FSPC_RD_IDLE;
      end
    end
  end

  fspc_link u_link (
    .i_lnk_clk (i_lnk_clk),
    .i_rst_b   (i_rst_b),
    .i_req_tgl (req_tgl),
    .i_xfer    (xfer),
    .i_io_in   (i_io_in),
    .o_ack_tgl (ack_tgl),
    .o_status  (lnk_stat),
    .o_pin     (pin)
  );

  assign o_cs_b        = pin.cs_b;
  assign o_sck_en      = pin.sck_en;
  assign o_io_out      = pin.io_out;
  assign o_io_oe       = pin.io_oe;
  assign o_poll_active = (st != C_IDLE);
  assign o_flash_ready = done;

  property p_busy_hi;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st == C_CHECK && busy_pos && returned[7]) |=> (st == C_REQ);
  endproperty
  a_busy_hi: assert property (p_busy_hi) else $error("bit 7 busy did not repoll");

  property p_busy_lo;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st == C_CHECK && !busy_pos && returned[0] != returned[7])
      |=> (st == C_REQ) == $past(returned[0]);
  endproperty
  a_busy_lo: assert property (p_busy_lo) else $error("bit 0 busy select not honoured");

  property p_capture;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st == C_WAIT && ack_new) |=> (returned == lnk_stat[15:8]) && (st == C_CHECK);
  endproperty
  a_capture: assert property (p_capture) else $error("returned status not captured");

  property p_cfg_read;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd_en && i_addr == FSPC_OFF_CFG)
      |=> o_rd_data[31:21] == 11'h000 && o_rd_data[20] == $past(busy_pos)
          && o_rd_data[19:18] == $past(lanes) && o_rd_data[7:0] == $past(opcode);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config word read back wrong");

  property p_ready_end;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st == C_CHECK && !flash_busy) |=> done && (st == C_IDLE) && o_flash_ready;
  endproperty
  a_ready_end: assert property (p_ready_end) else $error("poll did not finish on not busy");

  property p_no_early_done;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && start) |=> !done ##1 (o_poll_active && !done);
  endproperty
  a_no_early_done: assert property (p_no_early_done) else $error("done raised before any status read");

  property p_rd_idle;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && !i_rd_en) |=> (o_rd_data == FSPC_RD_IDLE);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle without strobe");

  property p_unmapped_read;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd_en && i_addr != FSPC_OFF_CFG && i_addr != FSPC_OFF_CTL)
      |=> (o_rd_data == FSPC_RD_IDLE);
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_cfg_len_read;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd_en && i_addr == FSPC_OFF_CFG)
      |=> o_rd_data[17:16] == $past(len_sel) && o_rd_data[15:8] == $past(returned);
  endproperty
  a_cfg_len_read: assert property (p_cfg_len_read) else $error("length or status field read back wrong");

  property p_cfg_write;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && cfg_wr)
      |=> busy_pos == $past(i_wr_data[FSPC_POS_BUSY]) && lanes == $past(i_wr_data[FSPC_LANE_LSB +: 2])
          && len_sel == $past(i_wr_data[FSPC_LEN_LSB +: 2]) && opcode == $past(i_wr_data[FSPC_OPC_LSB +: 8]);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write did not land");

  property p_ret_write;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && cfg_wr && !(st == C_WAIT && ack_new)) |=> (returned == $past(i_wr_data[FSPC_RET_LSB +: 8]));
  endproperty
  a_ret_write: assert property (p_ret_write) else $error("status field write did not land");

  property p_start_latch;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && start)
      |=> xfer.opcode == $past(opcode) && xfer.lanes == $past(lanes)
          && xfer.two_bytes == ($past(len_sel) == FSPC_LEN_2);
  endproperty
  a_start_latch: assert property (p_start_latch) else $error("transfer setup not latched at start");

  property p_cnt_start;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && start) |=> (poll_cnt == 8'h00);
  endproperty
  a_cnt_start: assert property (p_cnt_start) else $error("poll count not cleared at start");

  property p_req_toggle;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st == C_REQ) |=> (req_tgl != $past(req_tgl)) && (st == C_WAIT);
  endproperty
  a_req_toggle: assert property (p_req_toggle) else $error("status read not requested");

  property p_req_steady;
    @(posedge i_clk) disable iff (!i_rst_b)
    (st != C_REQ) |=> $stable(req_tgl);
  endproperty
  a_req_steady: assert property (p_req_steady) else $error("stray status read request");

  property p_wait_hold;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && st == C_WAIT && !ack_new) |=> (st == C_WAIT);
  endproperty
  a_wait_hold: assert property (p_wait_hold) else $error("left wait without link answer");

  property p_start_ignored;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && ctl_wr && i_wr_data[FSPC_CTL_START] && st != C_IDLE)
      |=> (poll_cnt != 8'h00);
  endproperty
  a_start_ignored: assert property (p_start_ignored) else $error("start taken during active poll");

  property p_clear_done;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && clear && !(st == C_CHECK && !flash_busy)) |=> !done;
  endproperty
  a_clear_done: assert property (p_clear_done) else $error("done flag not cleared");

  property p_ce_freeze;
    @(posedge i_clk) disable iff (!i_rst_b)
    !i_ce
      |=> $stable(st) && $stable(returned) && $stable(opcode) && $stable(done) && $stable(o_rd_data);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

  property p_ctl_read;
    @(posedge i_clk) disable iff (!i_rst_b)
    (i_ce && i_rd_en && i_addr == FSPC_OFF_CTL)
      |=> o_rd_data[0] == $past(o_poll_active) && o_rd_data[1] == $past(done)
          && o_rd_data[31:24] == $past(poll_cnt);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("poll status word read back wrong");

endmodule : fspc_top
`default_nettype wire

// file: include/fspc_pkg.sv
// Package for the flash status poll block: offsets, fields, codes, carriers
`default_nettype none
package fspc_pkg;

  localparam logic [7:0]  FSPC_OFF_CFG   = 8'h00;
  localparam logic [7:0]  FSPC_OFF_CTL   = 8'h04;
  localparam logic [31:0] FSPC_RD_IDLE   = 32'h0000_0000;

  localparam int          FSPC_POS_BUSY  = 20;
  localparam int          FSPC_LANE_LSB  = 18;
  localparam int          FSPC_LEN_LSB   = 16;
  localparam int          FSPC_RET_LSB   = 8;
  localparam int          FSPC_OPC_LSB   = 0;
  localparam int          FSPC_BUSY_HI   = 7;
  localparam int          FSPC_BUSY_LO   = 0;

  localparam int          FSPC_CTL_START = 0;
  localparam int          FSPC_CTL_CLR   = 1;
  localparam int          FSPC_ST_ACTIVE = 0;
  localparam int          FSPC_ST_DONE   = 1;

  localparam logic [1:0]  FSPC_LANE_1    = 2'h0;
  localparam logic [1:0]  FSPC_LANE_2    = 2'h1;
  localparam logic [1:0]  FSPC_LANE_4    = 2'h2;
  localparam logic [1:0]  FSPC_LEN_1     = 2'h1;
  localparam logic [1:0]  FSPC_LEN_2     = 2'h2;

  localparam logic [4:0]  FSPC_BYTE_BITS = 5'h08;
  localparam logic [7:0]  FSPC_CNT_MAX   = 8'hff;

  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] lanes;
    logic       two_bytes;
  } fspc_xfer_s;

  typedef struct packed {
    logic       cs_b;
    logic       sck_en;
    logic [3:0] io_out;
    logic [3:0] io_oe;
  } fspc_pin_s;

  typedef enum logic [1:0] {
    C_IDLE  = 2'h0,
    C_REQ   = 2'h1,
    C_WAIT  = 2'h3,
    C_CHECK = 2'h2
  } fspc_core_e;

  typedef enum logic [1:0] {
    L_IDLE = 2'h0,
    L_CMD  = 2'h1,
    L_RD   = 2'h3,
    L_END  = 2'h2
  } fspc_link_e;

  // Shift for lane width; the reserved code falls back to one lane
  function automatic logic [1:0] fspc_shift(input logic [1:0] lanes);
    case (lanes)
      FSPC_LANE_2: fspc_shift = 2'h1;
      FSPC_LANE_4: fspc_shift = 2'h2;
      default:     fspc_shift = 2'h0;
    endcase
  endfunction : fspc_shift

endpackage : fspc_pkg
`default_nettype wire

// file: core/fspc_link.sv
// Link-clock engine: sends the status opcode and shifts the status back in
`timescale 1ns/1ps
`default_nettype none
module fspc_link
  import fspc_pkg::*;
(
  input  wire logic        i_lnk_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req_tgl,
  input  wire fspc_xfer_s  i_xfer,
  input  wire logic [3:0]  i_io_in,
  output logic             o_ack_tgl,
  output logic [15:0]      o_status,
  output fspc_pin_s        o_pin
);

  logic [1:0]  rst_sync;
  logic        rst_b_l;
  logic        req_s1;
  logic        req_s2;
  logic        req_seen;
  logic        req_new;
  fspc_link_e  st;
  logic [4:0]  cnt;
  logic [7:0]  tx;
  logic [15:0] rx;
  logic [1:0]  sh;

  assign rst_b_l = rst_sync[1];
  assign req_new = req_s2 ^ req_seen;
  assign sh      = fspc_shift(i_xfer.lanes);

  always_ff @(posedge i_lnk_clk) begin
    rst_sync <= {rst_sync[0], i_rst_b};
  end

  always_ff @(posedge i_lnk_clk) begin
    if (!rst_b_l) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end else begin
      req_s1 <= i_req_tgl;
      req_s2 <= req_s1;
    end
  end

  always_ff @(posedge i_lnk_clk) begin
    if (!rst_b_l) begin
      st        <= L_IDLE;
      req_seen  <= 1'b0;
      cnt       <= 5'h00;
      tx        <= 8'h00;
      rx        <= 16'h0000;
      o_ack_tgl <= 1'b0;
      o_status  <= 16'h0000;
    end else begin
      case (st)
        L_IDLE: begin
          if (req_new) begin
            req_seen <= req_s2;
            tx       <= i_xfer.opcode;
            cnt      <= (FSPC_BYTE_BITS >> sh) - 5'h01;
            st       <= L_CMD;
          end
        end
        L_CMD: begin
          tx <= tx << (5'h01 << sh);
          if (cnt == 5'h00) begin
            cnt <= ((i_xfer.two_bytes ? 5'h10 : FSPC_BYTE_BITS) >> sh) - 5'h01;
            st  <= L_RD;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        L_RD: begin
          case (sh)
            2'h1:    rx <= {rx[13:0], i_io_in[1:0]};
            2'h2:    rx <= {rx[11:0], i_io_in};
            default: rx <= {rx[14:0], i_io_in[1]};
          endcase
          if (cnt == 5'h00) begin
            st <= L_END;
          end else begin
            cnt <= cnt - 5'h01;
          end
        end
        L_END: begin
          o_status  <= i_xfer.two_bytes ? rx : {rx[7:0], 8'h00};
          o_ack_tgl <= ~o_ack_tgl;
          st        <= L_IDLE;
        end
        default: st <= L_IDLE;
      endcase
    end
  end

  always_comb begin
    o_pin.cs_b   = (st == L_IDLE) || (st == L_END);
    o_pin.sck_en = (st == L_CMD) || (st == L_RD);
    o_pin.io_out = 4'h0;
    o_pin.io_oe  = 4'h0;
    if (st == L_CMD) begin
      case (sh)
        2'h1: begin
          o_pin.io_out = {2'h0, tx[7:6]};
          o_pin.io_oe  = 4'h3;
        end
        2'h2: begin
          o_pin.io_out = tx[7:4];
          o_pin.io_oe  = 4'hf;
        end
        default: begin
          o_pin.io_out = {3'h0, tx[7]};
          o_pin.io_oe  = 4'h1;
        end
      endcase
    end
  end

  property p_quad_lanes;
    @(posedge i_lnk_clk) disable iff (!rst_b_l)
    (st == L_CMD && i_xfer.lanes == FSPC_LANE_4) |-> o_pin.io_oe == 4'hf;
  endproperty
  a_quad_lanes: assert property (p_quad_lanes) else $error("quad command not on four lanes");

  property p_two_byte_len;
    @(posedge i_lnk_clk) disable iff (!rst_b_l)
    (st == L_IDLE && req_new && i_xfer.lanes == FSPC_LANE_4 && i_xfer.two_bytes)
      |=> (st == L_CMD)[*2] ##1 (st == L_RD)[*4] ##1 (st == L_END);
  endproperty
  a_two_byte_len: assert property (p_two_byte_len) else $error("two byte quad read wrong length");

  property p_one_byte_len;
    @(posedge i_lnk_clk) disable iff (!rst_b_l)
    (st == L_IDLE && req_new && i_xfer.lanes == FSPC_LANE_4 && !i_xfer.two_bytes)
      |=> (st == L_CMD)[*2] ##1 (st == L_RD)[*2] ##1 (st == L_END);
  endproperty
  a_one_byte_len: assert property (p_one_byte_len) else $error("one byte quad read wrong length");

  property p_opcode_first;
    @(posedge i_lnk_clk) disable iff (!rst_b_l)
    (st == L_IDLE && req_new && i_xfer.lanes == FSPC_LANE_1)
      |=> o_pin.io_out[0] == $past(i_xfer.opcode[7]) && o_pin.io_oe == 4'h1;
  endproperty
  a_opcode_first: assert property (p_opcode_first) else $error("opcode msb not sent first");

endmodule : fspc_link
`default_nettype wire

// file: tb/fspc_flash_model.sv
// Behavioural serial flash: takes the status opcode and shifts status bytes back
`timescale 1ns/1ps
`default_nettype none
module fspc_flash_model
  import fspc_pkg::*;
(
  input  wire logic        i_lnk_clk,
  input  wire logic        i_cs_b,
  input  wire logic        i_sck_en,
  input  wire logic [3:0]  i_io_out,
  input  wire logic [3:0]  i_io_oe,
  input  wire logic [7:0]  i_busy_byte,
  input  wire logic [7:0]  i_ready_byte,
  input  wire logic [7:0]  i_second_byte,
  input  wire logic [15:0] i_busy_until,
  output logic [3:0]       o_io_in,
  output logic [7:0]       o_opcode,
  output logic [2:0]       o_width,
  output logic [4:0]       o_rd_bits,
  output logic [15:0]      o_frames
);
  logic [3:0]  drv;
  logic [3:0]  cmd_cnt;
  logic [15:0] shreg;
  logic [15:0] cur;
  logic        was_sel;
  logic        fresh;

  initial begin
    drv = 4'h5;
    cmd_cnt = 4'h0;
    shreg = 16'h0000;
    cur = 16'h0000;
    was_sel = 1'b0;
    fresh = 1'b1;
    o_opcode = 8'h00;
    o_width = 3'h1;
    o_rd_bits = 5'h00;
    o_frames = 16'h0000;
  end

  // Wire level: the driving party wins; an undriven lane toggles every cycle
  assign o_io_in = (i_io_oe & i_io_out) | (~i_io_oe & drv);

  // Command phase: opcode taken MSB first at each flash clock rise
  always @(posedge i_lnk_clk) begin
    was_sel <= !i_cs_b;
    if (i_cs_b) begin
      cmd_cnt <= 4'h0;
      if (was_sel) begin
        o_frames <= o_frames + 16'h0001;
      end
    end else if (i_sck_en && i_io_oe != 4'h0 && cmd_cnt < 4'h8) begin
      case (i_io_oe)
        4'h3: begin
          o_opcode <= {o_opcode[5:0], i_io_out[1:0]};
          cmd_cnt <= cmd_cnt + 4'h2;
          o_width <= 3'h2;
        end
        4'hf: begin
          o_opcode <= {o_opcode[3:0], i_io_out};
          cmd_cnt <= cmd_cnt + 4'h4;
          o_width <= 3'h4;
        end
        default: begin
          o_opcode <= {o_opcode[6:0], i_io_out[0]};
          cmd_cnt <= cmd_cnt + 4'h1;
          o_width <= 3'h1;
        end
      endcase
    end
  end

  // Read phase: status bits put out on the falling edge, MSB first
  always @(negedge i_lnk_clk) begin
    if (!i_cs_b && cmd_cnt == 4'h8 && i_io_oe == 4'h0) begin
      cur = fresh ? {(o_frames < i_busy_until) ? i_busy_byte : i_ready_byte, i_second_byte} : shreg;
      case (o_width)
        3'h4: drv <= cur[15:12];
        3'h2: drv <= {~drv[3:2], cur[15:14]};
        default: drv <= {~drv[3:2], cur[15], ~drv[0]};
      endcase
      shreg <= cur << o_width;
      o_rd_bits <= fresh ? {2'h0, o_width} : o_rd_bits + {2'h0, o_width};
      fresh <= 1'b0;
    end else begin
      drv <= ~drv;
      if (cmd_cnt != 4'h8) begin
        fresh <= 1'b1;
      end
    end
  end
endmodule : fspc_flash_model
`default_nettype wire

// file: tb/fspc_top_test.sv
// Testbench for the flash status poll controller against the flash model
`timescale 1ns/1ps
`default_nettype none
module fspc_top_test
  import fspc_pkg::*;
;
  localparam logic [31:0] MODES [8] = '{32'h0001_0005, 32'h0012_0070, 32'h0015_0035, 32'h0006_009f,
                                        32'h0009_00d7, 32'h001a_000f, 32'h001d_00a5, 32'h0008_00c3};
  logic        clk, lnk_clk, rst_b, ce, wr_en, rd_en;
  logic [7:0]  addr;
  logic [31:0] wr_data, rd_data, cfg;
  logic [3:0]  io_in, io_out, io_oe;
  logic        cs_b, sck_en, poll_active, flash_ready;
  logic [7:0]  busy_byte, ready_byte, opcode_seen;
  logic [2:0]  width_seen, exp_width;
  logic [4:0]  rd_bits_seen;
  logic [15:0] busy_until, frames;
  int          mismatches, cmp_count, n;

  fspc_top uut (.i_clk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_addr(addr), .i_wr_data(wr_data),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data), .i_lnk_clk(lnk_clk), .i_io_in(io_in),
    .o_cs_b(cs_b), .o_sck_en(sck_en), .o_io_out(io_out), .o_io_oe(io_oe),
    .o_poll_active(poll_active), .o_flash_ready(flash_ready));

  fspc_flash_model model (.i_lnk_clk(lnk_clk), .i_cs_b(cs_b), .i_sck_en(sck_en), .i_io_out(io_out),
    .i_io_oe(io_oe), .i_busy_byte(busy_byte), .i_ready_byte(ready_byte), .i_second_byte(8'h3c),
    .i_busy_until(busy_until), .o_io_in(io_in), .o_opcode(opcode_seen), .o_width(width_seen),
    .o_rd_bits(rd_bits_seen), .o_frames(frames));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    lnk_clk = 1'b0;
    #20;
    forever #80 lnk_clk = ~lnk_clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask, input string name);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(name, exp & mask, rd_data & mask);
  endtask : rd

  initial begin
    #1_000_000;
    mismatches++;
    stop_test();
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wr_data = 32'h0000_0000;
    busy_byte = 8'h00;
    ready_byte = 8'h00;
    busy_until = 16'h0000;
    mismatches = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values, unmapped place, field widths, clock enable
    rd(FSPC_OFF_CFG, 32'h0000_0000, 32'hffff_ffff, "config reset");
    rd(FSPC_OFF_CTL, 32'h0000_0000, 32'hffff_ffff, "status reset");
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'h0000_0000, 32'hffff_ffff, "unmapped");
    rd(FSPC_OFF_CFG, 32'h0000_0000, 32'hffff_ffff, "config untouched");
    wr(FSPC_OFF_CFG, 32'hffff_ffff);
    rd(FSPC_OFF_CFG, 32'h001f_ffff, 32'hffff_ffff, "config fields");
    ce <= 1'b0;
    wr(FSPC_OFF_CFG, 32'h0000_0000);
    ce <= 1'b1;
    rd(FSPC_OFF_CFG, 32'h001f_ffff, 32'hffff_ffff, "config frozen");
    $display("test registers done");
    // Poll sessions over every lane and busy position code, length codes 00, 01 and 10
    for (int i = 0; i < 8; i++) begin
      cfg = MODES[i];
      busy_byte = cfg[20] ? 8'ha4 : 8'h25;
      ready_byte = cfg[20] ? 8'h5b : 8'hda;
      busy_until = frames + 16'h0002;
      exp_width = (cfg[19:18] == 2'h1) ? 3'h2 : (cfg[19:18] == 2'h2) ? 3'h4 : 3'h1;
      wr(FSPC_OFF_CFG, cfg);
      wr(FSPC_OFF_CTL, 32'h0000_0001);
      wr(FSPC_OFF_CTL, 32'h0000_0001);
      n = 0;
      while (flash_ready !== 1'b1 && n < 4000) begin
        @(posedge clk);
        n++;
      end
      #1;
      check("poll timeout", 32'h0, {31'h0, n >= 4000});
      check("opcode", {24'h0, cfg[7:0]}, {24'h0, opcode_seen});
      check("lane width", {29'h0, exp_width}, {29'h0, width_seen});
      check("read bits", (cfg[17:16] == 2'h2) ? 32'h10 : 32'h8, {27'h0, rd_bits_seen});
      check("pins idle", 32'h2, {29'h0, poll_active, cs_b, sck_en});
      rd(FSPC_OFF_CFG, cfg | {16'h0, ready_byte, 8'h00}, 32'hffff_ffff, "config status");
      rd(FSPC_OFF_CTL, 32'h0300_3c02, (cfg[17:16] == 2'h2) ? 32'hff00_ffff : 32'hff00_00ff, "poll status");
      wr(FSPC_OFF_CTL, 32'h0000_0002);
      rd(FSPC_OFF_CTL, 32'h0000_0000, 32'h0000_0003, "done clear");
      $display("test mode %0d done", i);
    end
    stop_test();
  end
endmodule : fspc_top_test
`default_nettype wire
